// File: common/frsp_map.vh
`ifndef FRSP_MAP_VH
`define FRSP_MAP_VH
// object indices
`define FRSP_IDX_ERR_REG      16'h1001
`define FRSP_IDX_HISTORY      16'h1003
`define FRSP_IDX_SYNC_ID      16'h1005
`define FRSP_IDX_CYCLE        16'h1006
// reset values
`define FRSP_SYNC_ID_RST      32'h00000080
`define FRSP_CYCLE_RST        32'h00000000
// field positions
`define FRSP_PRODUCER_BIT     30
`define FRSP_ID_MSB           10
`define FRSP_NUM_MSB          31
`define FRSP_NUM_LSB          24
`define FRSP_CLASS_MSB        23
`define FRSP_CLASS_LSB        16
`define FRSP_CODE_MSB         15
// timing
`define FRSP_CLK_HZ           10000000
`define FRSP_US_NS            1000
`define FRSP_CLK_NS           100
`define FRSP_CYC_PER_US       (`FRSP_US_NS / `FRSP_CLK_NS)
// fault causes
`define FRSP_C_WATCHDOG       5'd0
`define FRSP_C_GENERAL        5'd1
`define FRSP_C_OUT_CURRENT    5'd2
`define FRSP_C_VOLTAGE        5'd3
`define FRSP_C_TEMP           5'd4
`define FRSP_C_INTERLOCK      5'd5
`define FRSP_C_SW_GENERIC     5'd6
`define FRSP_C_RATED_CUR      5'd7
`define FRSP_C_BALLAST        5'd8
`define FRSP_C_BLOCKED        5'd9
`define FRSP_C_CORR_FACTOR    5'd10
`define FRSP_C_SENSOR1        5'd11
`define FRSP_C_SENSOR2        5'd12
`define FRSP_C_SENSOR3        5'd13
`define FRSP_C_SENSOR4UP      5'd14
`define FRSP_C_NVM            5'd15
`define FRSP_C_NVM_RESTART    5'd16
`define FRSP_C_BUS_MON        5'd17
`define FRSP_C_GUARD          5'd18
`define FRSP_C_PDO_LATE       5'd19
`define FRSP_C_PDO_LEN        5'd20
`define FRSP_C_PDO_LONG       5'd21
`define FRSP_C_SYNC_LEN       5'd22
`define FRSP_C_SLIP           5'd23
`define FRSP_C_FOLLOW         5'd24
`define FRSP_C_LIMIT          5'd25
`define FRSP_C_MOTOR_CFG      5'd26
`define FRSP_C_MOTOR_CUR      5'd27
`define FRSP_C_DOUT_CUR       5'd28
`endif

// File: hdl/frsp_encoder.v
`timescale 1ns/1ps
`include "frsp_map.vh"
module frsp_encoder (
  input  wire [4:0]  cause,
  input  wire [7:0]  err_class,
  output reg  [31:0] record
);
  reg [7:0]  num;
  reg [15:0] code;
  always @* begin
    num  = 8'h00;
    code = 16'h1000;
    case (cause)
      `FRSP_C_WATCHDOG:    begin num = 8'd0;  code = 16'h6010; end // RQ6
      `FRSP_C_GENERAL:     begin num = 8'd4;  code = 16'h1000; end // RQ5
      `FRSP_C_OUT_CURRENT: begin num = 8'd2;  code = 16'h2300; end // RQ5
      `FRSP_C_VOLTAGE:     begin num = 8'd1;  code = 16'h3100; end // RQ5
      `FRSP_C_TEMP:        begin num = 8'd12; code = 16'h4200; end // RQ5
      `FRSP_C_INTERLOCK:   begin num = 8'd46; code = 16'h5540; end // RQ3
      `FRSP_C_SW_GENERIC:  begin num = 8'd25; code = 16'h6100; end // RQ3
      `FRSP_C_RATED_CUR:   begin num = 8'd22; code = 16'h6320; end // RQ2
      `FRSP_C_BALLAST:     begin num = 8'd40; code = 16'h7113; end // RQ3
      `FRSP_C_BLOCKED:     begin num = 8'd15; code = 16'h7121; end // RQ7
      `FRSP_C_CORR_FACTOR: begin num = 8'd32; code = 16'h7200; end // RQ3
      `FRSP_C_SENSOR1:     begin num = 8'd7;  code = 16'h7305; end // RQ7
      `FRSP_C_SENSOR2:     begin num = 8'd8;  code = 16'h7306; end // RQ7
      `FRSP_C_SENSOR3:     begin num = 8'd9;  code = 16'h7307; end // RQ7
      `FRSP_C_SENSOR4UP:   begin num = 8'd18; code = 16'h7307; end // RQ2
      `FRSP_C_NVM:         begin num = 8'd14; code = 16'h7600; end // RQ7
      `FRSP_C_NVM_RESTART: begin num = 8'd21; code = 16'h7600; end // RQ2
      `FRSP_C_BUS_MON:     begin num = 8'd4;  code = 16'h8100; end // RQ8
      `FRSP_C_GUARD:       begin num = 8'd6;  code = 16'h8130; end // RQ8
      `FRSP_C_PDO_LATE:    begin num = 8'd17; code = 16'h8200; end // RQ9
      `FRSP_C_PDO_LEN:     begin num = 8'd19; code = 16'h8210; end // RQ1
      `FRSP_C_PDO_LONG:    begin num = 8'd20; code = 16'h8220; end // RQ1
      `FRSP_C_SYNC_LEN:    begin num = 8'd27; code = 16'h8240; end // RQ1
      `FRSP_C_SLIP:        begin num = 8'd30; code = 16'h8400; end // RQ3
      `FRSP_C_FOLLOW:      begin num = 8'd13; code = 16'h8611; end // RQ10
      `FRSP_C_LIMIT:       begin num = 8'd10; code = 16'h8612; end // RQ10
      `FRSP_C_MOTOR_CFG:   begin num = 8'd23; code = 16'h1000; end // RQ2
      `FRSP_C_MOTOR_CUR:   begin num = 8'd24; code = 16'h2300; end // RQ3
      `FRSP_C_DOUT_CUR:    begin num = 8'd26; code = 16'h2300; end // RQ3
      default:             begin num = 8'd25; code = 16'h6100; end
    endcase
    record = {num, err_class, code}; // RQ19 RQ4
  end
endmodule // frsp_encoder

// File: hdl/frsp_sync_timer.v
`timescale 1ns/1ps
`include "frsp_map.vh"
module frsp_sync_timer #(
  parameter CYC_PER_US = `FRSP_CYC_PER_US
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        enable,
  input  wire [31:0] period_us,
  output reg         tick
);
  reg [15:0] pre;
  reg [31:0] us_cnt;
  wire       us_tick = (pre == CYC_PER_US - 1);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre    <= 16'h0000;
      us_cnt <= 32'h00000000;
      tick   <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (!enable || period_us == 32'h00000000) begin
        pre    <= 16'h0000;
        us_cnt <= 32'h00000000;
      end else begin
        pre <= us_tick ? 16'h0000 : pre + 16'h0001;
        if (us_tick) begin
          if (us_cnt >= period_us - 32'h00000001) begin
            us_cnt <= 32'h00000000;
            tick   <= 1'b1; // RQ15
          end else begin
            us_cnt <= us_cnt + 32'h00000001;
          end
        end
      end
    end
  end
endmodule // frsp_sync_timer

// File: hdl/frsp_top.v
// Function
// RQ1 - PDO length faults get numbers 19, 20; unexpected sync length 27.
// RQ2 - Numbers 18 sensor four up, 21 storage restart, 22 rated current, 23 config.
// RQ3 - Numbers 24, 25, 26, 30, 32, 40, 46 for listed faults.
// RQ4 - Error class byte copies the current error register value.
// RQ5 - Codes 1000h, 2300h, 3100h, 4200h for general, current, voltage, temperature.
// RQ6 - Codes 5540h interlock, 6010h watchdog, 6100h software, 6320h rated current.
// RQ7 - Codes 7113h, 7121h, 7200h, 7305h-7307h sensors, 7600h storage.
// RQ8 - Codes 8100h bus monitoring, 8130h guard or heartbeat.
// RQ9 - Codes 8200h, 8210h, 8220h, 8240h for PDO and sync faults.
// RQ10 - Codes 8400h slip, 8611h following error, 8612h limit switch.
// RQ11 - Writer supplies a valid 11-bit standard identifier.
// RQ12 - New sync identifier takes effect only at restart or reset-communication.
// RQ13 - Sync identifier defaults to 80h.
// RQ14 - Bit 30 set makes the device the sync producer.
// RQ15 - Sync sent every cycle period microseconds; writers use 1000 us multiples.
// RQ16 - Writer picks an unassigned identifier.
// RQ17 - Both sync objects readable, writable and saved with communication settings.
// RQ18 - New record enters entry 1, others shift down, oldest dropped.
// RQ19 - Record holds number 31:24, class 23:16, code 15:0.
`timescale 1ns/1ps
`include "frsp_map.vh"
module frsp_top #(
  parameter DEPTH = 8
) (
  input  wire        CLK_SYS,
  input  wire        ARST_N,
  input  wire        OBJ_WR,
  input  wire        OBJ_RD,
  input  wire [15:0] OBJ_INDEX,
  input  wire [7:0]  OBJ_SUB,
  input  wire [31:0] OBJ_WDATA,
  output reg  [31:0] OBJ_RDATA,
  output reg         OBJ_ACK,
  output reg         OBJ_ABORT,
  input  wire        RESET_COMM,
  input  wire        NV_LOAD,
  input  wire [31:0] NV_SYNC_ID,
  input  wire [31:0] NV_CYCLE,
  output wire [31:0] NV_SAVE_SYNC_ID,
  output wire [31:0] NV_SAVE_CYCLE,
  input  wire [7:0]  ERROR_REG,
  input  wire        FAULT_STB,
  input  wire [4:0]  FAULT_CAUSE,
  output reg  [31:0] NEW_RECORD,
  output reg  [7:0]  ERR_COUNT,
  output reg  [10:0] SYNC_ID_ACTIVE,
  output reg         SYNC_PRODUCER,
  output wire        SYNC_TX
);
  // ****************************************
  // reset release
  // ****************************************
  reg  rst_q1;
  reg  rst_n;
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end
  // ****************************************
  // sync configuration objects
  // ****************************************
  reg  [31:0] sync_identifier;
  reg  [31:0] sync_cycle_period;
  reg         started;
  wire        wr_id  = OBJ_WR && OBJ_INDEX == `FRSP_IDX_SYNC_ID && OBJ_SUB == 8'h00;
  wire        wr_cyc = OBJ_WR && OBJ_INDEX == `FRSP_IDX_CYCLE && OBJ_SUB == 8'h00;
  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      sync_identifier   <= `FRSP_SYNC_ID_RST; // RQ13
      sync_cycle_period <= `FRSP_CYCLE_RST;
    end else if (NV_LOAD) begin
      sync_identifier   <= NV_SYNC_ID; // RQ17
      sync_cycle_period <= NV_CYCLE;
    end else begin
      if (wr_id)
        sync_identifier <= OBJ_WDATA; // RQ17
      if (wr_cyc)
        sync_cycle_period <= OBJ_WDATA; // RQ17 RQ15
    end
  end
  assign NV_SAVE_SYNC_ID = sync_identifier; // RQ17
  assign NV_SAVE_CYCLE   = sync_cycle_period;
  // identifier and producer role latched only at restart or reset-communication
  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      started        <= 1'b0;
      SYNC_ID_ACTIVE <= 11'h000;
      SYNC_PRODUCER  <= 1'b0;
    end else begin
      started <= 1'b1;
      if (!started || RESET_COMM) begin
        SYNC_ID_ACTIVE <= sync_identifier[`FRSP_ID_MSB:0]; // RQ12 RQ11
        SYNC_PRODUCER  <= sync_identifier[`FRSP_PRODUCER_BIT]; // RQ14 RQ12
      end
    end
  end
  frsp_sync_timer #(
    .CYC_PER_US (`FRSP_CYC_PER_US)
  ) u_timer (
    .clk       (CLK_SYS),
    .rst_n     (rst_n),
    .enable    (SYNC_PRODUCER), // RQ14
    .period_us (sync_cycle_period),
    .tick      (SYNC_TX)
  );
  // ****************************************
  // fault history
  // ****************************************
  wire [31:0] record;
  reg  [31:0] history [0:DEPTH-1];
  integer     i;
  frsp_encoder u_enc (
    .cause     (FAULT_CAUSE),
    .err_class (ERROR_REG), // RQ4
    .record    (record)
  );
  wire clr_count = OBJ_WR && OBJ_INDEX == `FRSP_IDX_HISTORY && OBJ_SUB == 8'h00 &&
                   OBJ_WDATA[7:0] == 8'h00;
  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < DEPTH; i = i + 1)
        history[i] <= 32'h00000000;
      NEW_RECORD <= 32'h00000000;
      ERR_COUNT  <= 8'h00;
    end else begin
      if (FAULT_STB) begin
        history[0] <= record; // RQ18
        for (i = 1; i < DEPTH; i = i + 1)
          history[i] <= history[i-1]; // RQ18
        NEW_RECORD <= record;
        // a fault in the clearing cycle still counts
        if (clr_count)
          ERR_COUNT <= 8'h01;
        else if (ERR_COUNT < DEPTH)
          ERR_COUNT <= ERR_COUNT + 8'h01;
      end else if (clr_count) begin
        ERR_COUNT <= 8'h00;
      end
    end
  end
  // ****************************************
  // object read port and write acknowledge
  // ****************************************
  wire hist_ok = OBJ_SUB != 8'h00 && OBJ_SUB <= ERR_COUNT;
  always @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      OBJ_RDATA <= 32'h00000000;
      OBJ_ACK   <= 1'b0;
      OBJ_ABORT <= 1'b0;
    end else begin
      OBJ_ACK   <= 1'b0;
      OBJ_ABORT <= 1'b0;
      if (OBJ_RD) begin
        OBJ_ACK   <= 1'b1;
        OBJ_RDATA <= 32'h00000000;
        case (OBJ_INDEX)
          `FRSP_IDX_SYNC_ID: OBJ_RDATA <= sync_identifier; // RQ17
          `FRSP_IDX_CYCLE:   OBJ_RDATA <= sync_cycle_period; // RQ17
          `FRSP_IDX_ERR_REG: OBJ_RDATA <= {24'h000000, ERROR_REG};
          `FRSP_IDX_HISTORY: begin
            if (OBJ_SUB == 8'h00)
              OBJ_RDATA <= {24'h000000, ERR_COUNT};
            else if (hist_ok)
              OBJ_RDATA <= history[OBJ_SUB[2:0] - 3'd1];
            else
              OBJ_ABORT <= 1'b1;
          end
          default: OBJ_ABORT <= 1'b1;
        endcase
      end else if (OBJ_WR) begin
        OBJ_ACK <= 1'b1;
        if (!(wr_id || wr_cyc || clr_count))
          OBJ_ABORT <= 1'b1;
      end
    end
  end
endmodule // frsp_top

// File: test/frsp_top_properties.sv
`timescale 1ns/1ps
module frsp_top_properties #(
  parameter DEPTH = 8
) (
  input logic        CLK_SYS,
  input logic        ARST_N,
  input logic        OBJ_WR,
  input logic        OBJ_RD,
  input logic        OBJ_ACK,
  input logic        OBJ_ABORT,
  input logic        RESET_COMM,
  input logic [31:0] NV_SAVE_SYNC_ID,
  input logic [7:0]  ERROR_REG,
  input logic        FAULT_STB,
  input logic [31:0] NEW_RECORD,
  input logic [7:0]  ERR_COUNT,
  input logic [10:0] SYNC_ID_ACTIVE,
  input logic        SYNC_PRODUCER,
  input logic        SYNC_TX
);
  logic [31:0] prev_save;
  always @(posedge CLK_SYS) prev_save <= NV_SAVE_SYNC_ID;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  sequence req_taken; OBJ_RD || OBJ_WR; endsequence
  sequence sync_quiet; !SYNC_TX [*8]; endsequence
  ack_follows_a: assert property (req_taken |=> OBJ_ACK)
    else $error("request not answered");
  ack_cause_a: assert property (OBJ_ACK |-> $past(OBJ_RD || OBJ_WR))
    else $error("answer without request");
  abort_with_ack_a: assert property (OBJ_ABORT |-> OBJ_ACK)
    else $error("abort without answer");
  record_class_a: assert property (FAULT_STB |=> NEW_RECORD[23:16] == $past(ERROR_REG))
    else $error("class byte differs from error register");
  count_step_a: assert property (FAULT_STB && !OBJ_WR && ERR_COUNT < DEPTH |=>
    ERR_COUNT == $past(ERR_COUNT) + 8'h01) else $error("count not advanced");
  count_cap_a: assert property (ERR_COUNT <= DEPTH)
    else $error("count above depth");
  id_hold_a: assert property ($changed(SYNC_ID_ACTIVE) && $past(SYNC_ID_ACTIVE) != 11'h000
    |-> $past(RESET_COMM)) else $error("identifier changed without command");
  id_reload_a: assert property (RESET_COMM |=> SYNC_ID_ACTIVE == prev_save[10:0]
    && SYNC_PRODUCER == prev_save[30]) else $error("identifier not reloaded");
  sync_owner_a: assert property (SYNC_TX |-> $past(SYNC_PRODUCER))
    else $error("sync sent while not producer");
  sync_gap_a: assert property (SYNC_TX |=> sync_quiet)
    else $error("sync frames too close");
endmodule // frsp_top_properties

bind frsp_top frsp_top_properties #(.DEPTH(DEPTH)) frsp_top_properties_inst (
  .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .OBJ_WR(OBJ_WR), .OBJ_RD(OBJ_RD), .OBJ_ACK(OBJ_ACK),
  .OBJ_ABORT(OBJ_ABORT), .RESET_COMM(RESET_COMM), .NV_SAVE_SYNC_ID(NV_SAVE_SYNC_ID),
  .ERROR_REG(ERROR_REG), .FAULT_STB(FAULT_STB), .NEW_RECORD(NEW_RECORD),
  .ERR_COUNT(ERR_COUNT), .SYNC_ID_ACTIVE(SYNC_ID_ACTIVE), .SYNC_PRODUCER(SYNC_PRODUCER),
  .SYNC_TX(SYNC_TX));

// File: test/frsp_sync_node.sv
`timescale 1ns/1ps
module frsp_sync_node (
  input logic clk,
  input logic sync_tx,
  output int  gap,
  output int  seen
);
  int run = 0;
  initial gap = 0;
  initial seen = 0;
  // consumer side: spacing between received sync frames
  always @(posedge clk) begin
    run <= sync_tx ? 0 : run + 1;
    if (sync_tx) begin
      gap  <= run + 1;
      seen <= seen + 1;
    end
  end
endmodule // frsp_sync_node

// File: test/frsp_top_tb.sv
`timescale 1ns/1ps
module frsp_top_tb;
  logic        clk = 1'b0, arst_n = 1'b0, obj_wr = 1'b0, obj_rd = 1'b0, reset_comm = 1'b0;
  logic        nv_load = 1'b0, fault_stb = 1'b0, obj_ack, obj_abort, sync_producer, sync_tx;
  logic [15:0] obj_index = 16'h0000;
  logic [7:0]  obj_sub = 8'h00, error_reg = 8'h00, err_count;
  logic [31:0] obj_wdata = 32'h0, nv_sync_id = 32'h0, nv_cycle = 32'h0;
  logic [31:0] obj_rdata, new_record, save_id, save_cyc, exp;
  logic [4:0]  fault_cause = 5'h00;
  logic [10:0] sync_id_active;
  logic [31:0] recs [29];
  int          errors = 0, n_tests = 0, gap, seen;
  // ****************
  // number and code per cause
  // ****************
  logic [23:0] tbl [29] = '{24'h006010, 24'h041000, 24'h022300, 24'h013100, 24'h0c4200,
    24'h2e5540, 24'h196100, 24'h166320, 24'h287113, 24'h0f7121, 24'h207200, 24'h077305,
    24'h087306, 24'h097307, 24'h127307, 24'h0e7600, 24'h157600, 24'h048100, 24'h068130,
    24'h118200, 24'h138210, 24'h148220, 24'h1b8240, 24'h1e8400, 24'h0d8611, 24'h0a8612,
    24'h171000, 24'h182300, 24'h1a2300};
  always #50 clk = ~clk;
  frsp_top #(.DEPTH(8)) frsp_top_inst (.CLK_SYS(clk), .ARST_N(arst_n), .OBJ_WR(obj_wr),
    .OBJ_RD(obj_rd), .OBJ_INDEX(obj_index), .OBJ_SUB(obj_sub), .OBJ_WDATA(obj_wdata),
    .OBJ_RDATA(obj_rdata), .OBJ_ACK(obj_ack), .OBJ_ABORT(obj_abort),
    .RESET_COMM(reset_comm), .NV_LOAD(nv_load), .NV_SYNC_ID(nv_sync_id),
    .NV_CYCLE(nv_cycle), .NV_SAVE_SYNC_ID(save_id), .NV_SAVE_CYCLE(save_cyc),
    .ERROR_REG(error_reg), .FAULT_STB(fault_stb), .FAULT_CAUSE(fault_cause),
    .NEW_RECORD(new_record), .ERR_COUNT(err_count), .SYNC_ID_ACTIVE(sync_id_active),
    .SYNC_PRODUCER(sync_producer), .SYNC_TX(sync_tx));
  frsp_sync_node frsp_sync_node_inst (.clk(clk), .sync_tx(sync_tx), .gap(gap), .seen(seen));
  task chk(input string what, input logic [31:0] e, input logic [31:0] got);
    n_tests++;
    if (got !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, got);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task obj(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
           input logic [31:0] wd, input logic ab);
    int i;
    obj_wr = wr; obj_rd = !wr; obj_index = idx; obj_sub = sub; obj_wdata = wd;
    @(negedge clk);
    obj_wr = 1'b0; obj_rd = 1'b0;
    for (i = 0; i < 4 && obj_ack !== 1'b1; i++) @(negedge clk);
    if (obj_ack !== 1'b1) begin
      errors++;
      test_done;
    end
    chk("abort", {31'h0, ab}, {31'h0, obj_abort});
    // one idle edge so back-to-back calls never reassign a strobe in one step
    @(negedge clk);
  endtask
  task rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] e);
    obj(1'b0, idx, sub, 32'h0, 1'b0);
    chk("rdata", e, obj_rdata);
  endtask
  task rst;
    arst_n = 1'b0;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  task pulse_comm;
    reset_comm = 1'b1;
    @(negedge clk);
    reset_comm = 1'b0;
    @(negedge clk);
  endtask
  initial begin
    rst;
    for (int i = 0; i < 29; i++) begin
      fault_stb = 1'b1; fault_cause = i[4:0]; error_reg = 8'h40 + i[7:0];
      @(negedge clk);
      fault_stb = 1'b0;
      @(negedge clk);
      exp = {tbl[i][23:16], error_reg, tbl[i][15:0]};
      chk("record", exp, new_record);
      recs[i] = exp;
    end
    chk("count", 32'h8, {24'h0, err_count});
    rd(16'h1001, 8'h00, 32'h5c);
    rd(16'h1003, 8'h00, 32'h8);
    rd(16'h1003, 8'h01, recs[28]);
    rd(16'h1003, 8'h08, recs[21]);
    obj(1'b0, 16'h1003, 8'h09, 32'h0, 1'b1);
    obj(1'b1, 16'h1003, 8'h00, 32'h5, 1'b1);
    obj(1'b1, 16'h1003, 8'h00, 32'h0, 1'b0);
    obj(1'b0, 16'h1003, 8'h01, 32'h0, 1'b1);
    obj(1'b0, 16'h1234, 8'h00, 32'h0, 1'b1);
    rst;
    rd(16'h1005, 8'h00, 32'h80);
    rd(16'h1006, 8'h00, 32'h0);
    chk("active", 32'h80, {21'h0, sync_id_active});
    obj(1'b1, 16'h1006, 8'h00, 32'd1000, 1'b0);
    obj(1'b1, 16'h1005, 8'h00, 32'h40000081, 1'b0);
    chk("active", 32'h80, {21'h0, sync_id_active});
    rd(16'h1005, 8'h00, 32'h40000081);
    chk("save id", 32'h40000081, save_id);
    chk("save cycle", 32'd1000, save_cyc);
    pulse_comm;
    chk("active", 32'h81, {21'h0, sync_id_active});
    chk("producer", 32'h1, {31'h0, sync_producer});
    // 1000 us at 10 cycles per us: frames sampled 10000, 20000 and 30000 edges on
    repeat (30010) @(negedge clk);
    chk("gap", 32'd10000, gap);
    chk("frames", 32'd3, seen);
    nv_sync_id = 32'h85; nv_load = 1'b1;
    @(negedge clk);
    nv_load = 1'b0;
    rd(16'h1005, 8'h00, 32'h85);
    pulse_comm;
    chk("producer", 32'h0, {31'h0, sync_producer});
    chk("active", 32'h85, {21'h0, sync_id_active});
    test_done;
  end
endmodule // frsp_top_tb
